// file: nvmp_defines.svh
// Purpose: shared constants of the nvm protection register block
// Assumes: 32-bit axi4-lite, one word per register, index = byte addr / 4
// Notes: no processes here, definitions only
`ifndef NVMP_DEFINES_SVH
`define NVMP_DEFINES_SVH

// register indices, byte address is four times the index
`define NVMP_IDX_CMD_INDEX 4'h1
`define NVMP_IDX_STATUS 4'h6
`define NVMP_IDX_FLASH_PROTECT_CTRL 4'h8
`define NVMP_IDX_EEPROM_PROTECT_CTRL 4'h9
`define NVMP_IDX_CCOB_HI 4'ha
`define NVMP_IDX_CCOB_LO 4'hb
`define NVMP_IDX_OPTION 4'hc

// configuration bytes fetched during the reset sequence
`define NVMP_CFG_FLASH_PROTECT_CTRL_ADDR 16'hff7c
`define NVMP_CFG_EEPROM_PROTECT_CTRL_ADDR 16'hff7d
`define NVMP_CFG_OPTION_ADDR 16'hff7e
`define NVMP_CFG_LAST_SEL 2'h2

// flash range anchors
`define NVMP_UPPER_END_P1 17'h10000
`define NVMP_LOWER_BASE 17'h08000

// reset values before the configuration load
`define NVMP_FLASH_PROTECT_CTRL_RST 8'hff
`define NVMP_EEPROM_PROTECT_CTRL_RST 8'h80
`define NVMP_OPTION_RST 8'h00

// command object geometry
`define NVMP_CCOB_WORDS 6
`define NVMP_CCOB_IDX_MAX 3'h5

// status bit position
`define NVMP_STAT_VIOL_BIT 4

// axi responses
`define NVMP_RESP_OKAY 2'h0
`define NVMP_RESP_SLVERR 2'h2

`endif

// file: nvmp_pkg.sv
// Purpose: types of the nvm protection register block
// Assumes: constants live in nvmp_defines.svh
// Notes: every use is written nvmp_pkg::name
`include "nvmp_defines.svh"
package nvmp_pkg;

  typedef struct packed {
    logic range_sense_select;
    logic fixed_one;
    logic upper_range_disable;
    logic [1:0] upper_range_size;
    logic lower_range_disable;
    logic [1:0] lower_range_size;
  } nvmp_flash_protect_ctrl_t;

  typedef struct packed {
    logic eeprom_guard_enable_n;
    logic [3:0] zeros;
    logic [2:0] eeprom_guard_size;
  } nvmp_eeprom_protect_ctrl_t;

  typedef enum logic [1:0] {
    NVMP_OP_PROGRAM,
    NVMP_OP_SECTOR_ERASE,
    NVMP_OP_BLOCK_ERASE
  } nvmp_op_kind_t;

  typedef struct packed {
    logic valid;
    nvmp_op_kind_t kind;
    logic eeprom;
    logic [15:0] addr;
  } nvmp_op_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] wr_idx;
    logic [3:0] rd_idx;
    logic [7:0] wdata;
  } nvmp_regreq_t;

  typedef enum {
    NVMP_LOAD,
    NVMP_RUN
  } nvmp_phase_t;

  typedef struct packed {
    logic aw_held;
    logic [3:0] aw_idx;
    logic w_held;
    logic [7:0] wdata;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } nvmp_axi_state_t;

  typedef struct packed {
    nvmp_phase_t phase;
    logic [1:0] cfg_sel;
    nvmp_flash_protect_ctrl_t flash_protect_ctrl;
    nvmp_eeprom_protect_ctrl_t eeprom_protect_ctrl;
    logic [7:0] option_bits;
    logic [2:0] command_word_index;
    logic [`NVMP_CCOB_WORDS*16-1:0] ccob;
    logic protection_violation_flag;
    logic op_done;
    logic op_refused;
  } nvmp_state_t;

endpackage

// file: nvmp_axil_slave.sv
// Purpose: axi4-lite slave front end for byte-wide registers
// Assumes: one write and one read under way at most
// Notes: register side decodes the index, this side handshakes and checks upper address bits
`timescale 1ns/1ps
`include "nvmp_defines.svh"
module nvmp_axil_slave (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic stall,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output nvmp_pkg::nvmp_regreq_t req,
  input wire logic wr_mapped,
  input wire logic rd_mapped,
  input wire logic [7:0] rd_data
);

  nvmp_pkg::nvmp_axi_state_t s_r;
  nvmp_pkg::nvmp_axi_state_t s_nxt;
  logic do_wr;
  logic do_rd;

  assign s_axi_awready = !s_r.aw_held && !s_r.bvalid;
  assign s_axi_wready = !s_r.w_held && !s_r.bvalid;
  // registers are not served while the configuration load runs
  assign s_axi_arready = !s_r.rvalid && !stall;
  assign s_axi_bvalid = s_r.bvalid;
  assign s_axi_bresp = s_r.bresp;
  assign s_axi_rvalid = s_r.rvalid;
  assign s_axi_rdata = s_r.rdata;
  assign s_axi_rresp = s_r.rresp;

  assign do_wr = s_r.aw_held && s_r.w_held && !stall;
  assign do_rd = s_axi_arvalid && s_axi_arready;

  always_comb begin
    req.wr = do_wr && s_r.w_lane0 && wr_mapped;
    req.wr_idx = s_r.aw_idx;
    req.wdata = s_r.wdata;
    req.rd = do_rd;
    req.rd_idx = s_axi_araddr[5:2];
  end

  always_comb begin
    s_nxt = s_r;
    if (s_axi_awvalid && s_axi_awready) begin
      s_nxt.aw_held = 1'b1;
      // upper address bits must be zero for a mapped register
      s_nxt.aw_idx = (s_axi_awaddr[31:6] == 26'h0000000) ?
        s_axi_awaddr[5:2] : 4'hf;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_nxt.w_held = 1'b1;
      s_nxt.wdata = s_axi_wdata[7:0];
      s_nxt.w_lane0 = s_axi_wstrb[0];
    end
    if (do_wr) begin
      s_nxt.aw_held = 1'b0;
      s_nxt.w_held = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = wr_mapped ? `NVMP_RESP_OKAY : `NVMP_RESP_SLVERR;
    end else if (s_r.bvalid && s_axi_bready) begin
      s_nxt.bvalid = 1'b0;
    end
    if (do_rd) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = {24'h000000, rd_data};
      s_nxt.rresp = (rd_mapped && s_axi_araddr[31:6] == 26'h0000000) ?
        `NVMP_RESP_OKAY : `NVMP_RESP_SLVERR;
    end else if (s_r.rvalid && s_axi_rready) begin
      s_nxt.rvalid = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule

// file: nvmp_top.sv
// Purpose: flash and eeprom protection, command object and option regs
// Assumes: config bytes come from a flash read port after reset
// Notes: command execution itself lives outside this block
//
// What this block does
// - reset sequence loads flash protection from config byte at 0xFF7C.
// - flash protection writes apply only the changes that do not shrink the protected region.
// - program or erase on protected flash is refused and sets violation flag.
// - flash block erase refused while any sector of that block is protected.
// - bit 7 picks sense: clear means ranges unprotected, set means protected.
// - flash protection bit 6 is read-only and reads one.
// - bit 5 disables upper range ending at 0xFFFF; zero enables it.
// - upper size bits 4:3 writable only while upper disable bit is set.
// - bit 2 disables lower range starting at 0x8000; zero enables it.
// - lower size bits 1:0 writable only while lower disable bit is set.
// - eeprom protection only grows: size must rise, enable only one to zero.
// - eeprom bit 7 zero enables protection; while one, size is ignored.
// - reset sequence loads eeprom enable and size from byte at 0xFF7D.
// - program or erase on protected eeprom is refused and sets violation flag.
// - eeprom block erase refused while any eeprom sector is protected.
// - eeprom bits 6:3 read zero; bits 2:0 give protected area size.
// - command object is six words picked by a separate index register.
// - high byte register maps bits 15:8, low byte register bits 7:0.
// - reset sequence loads all eight option bits from byte at 0xFF7E.
`timescale 1ns/1ps
`include "nvmp_defines.svh"
module nvmp_top #(
  parameter int FLASH_UNIT_LOG2 = 10,
  parameter int EE_UNIT_LOG2 = 5
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic cfg_rd_req,
  output logic [15:0] cfg_rd_addr,
  input wire logic cfg_rd_valid,
  input wire logic [7:0] cfg_rd_data,
  input wire nvmp_pkg::nvmp_op_t op,
  output logic op_ready,
  output logic op_done,
  output logic op_refused,
  output logic protection_violation_flag,
  output logic [7:0] option_bits,
  output logic [15:0] command_word
);

  ////////////////////////////////////////////////////////////////////////
  // elaboration checks

  // region sizes must fit the 32 kbyte flash window and 64 kbyte space
  if (FLASH_UNIT_LOG2 < 0 || FLASH_UNIT_LOG2 > 12) begin : g_chk_flash
    $error("FLASH_UNIT_LOG2 out of range");
  end
  if (EE_UNIT_LOG2 < 0 || EE_UNIT_LOG2 > 12) begin : g_chk_ee
    $error("EE_UNIT_LOG2 out of range");
  end

  ////////////////////////////////////////////////////////////////////////
  // functions

  // size of a flash range in bytes
  function automatic logic [16:0] range_bytes(input logic [1:0] sz);
    logic [16:0] unit;
    unit = 17'h00001 << FLASH_UNIT_LOG2;
    range_bytes = unit << sz;
  endfunction

  // flash byte falls in the enabled upper range
  function automatic logic in_upper(input nvmp_pkg::nvmp_flash_protect_ctrl_t f,
                                    input logic [15:0] a);
    logic [16:0] start;
    start = `NVMP_UPPER_END_P1 - range_bytes(f.upper_range_size);
    in_upper = !f.upper_range_disable && ({1'b0, a} >= start);
  endfunction

  // flash byte falls in the enabled lower range
  function automatic logic in_lower(input nvmp_pkg::nvmp_flash_protect_ctrl_t f,
                                    input logic [15:0] a);
    logic [16:0] lim;
    lim = `NVMP_LOWER_BASE + range_bytes(f.lower_range_size);
    in_lower = !f.lower_range_disable &&
      ({1'b0, a} >= `NVMP_LOWER_BASE) && ({1'b0, a} < lim);
  endfunction

  // protection of one flash byte under the chosen sense
  function automatic logic flash_prot(input nvmp_pkg::nvmp_flash_protect_ctrl_t f,
                                      input logic [15:0] a);
    logic hit;
    hit = in_upper(f, a) || in_lower(f, a);
    flash_prot = f.range_sense_select ? hit : !hit;
  endfunction

  function automatic logic ee_prot(input nvmp_pkg::nvmp_eeprom_protect_ctrl_t e,
                                   input logic [15:0] a);
    logic [16:0] lim;
    lim = ({14'h0000, e.eeprom_guard_size} + 17'h00001) << EE_UNIT_LOG2;
    // enable bit high masks the size field completely
    ee_prot = !e.eeprom_guard_enable_n && ({1'b0, a} < lim);
  endfunction

  function automatic logic mapped(input logic [3:0] idx);
    case (idx)
      `NVMP_IDX_CMD_INDEX,
      `NVMP_IDX_STATUS,
      `NVMP_IDX_FLASH_PROTECT_CTRL,
      `NVMP_IDX_EEPROM_PROTECT_CTRL,
      `NVMP_IDX_CCOB_HI,
      `NVMP_IDX_CCOB_LO,
      `NVMP_IDX_OPTION: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  endfunction

  // option byte is read-only
  function automatic logic writable(input logic [3:0] idx);
    writable = mapped(idx) && (idx != `NVMP_IDX_OPTION);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // bus front end

  nvmp_pkg::nvmp_state_t s_r;
  nvmp_pkg::nvmp_state_t s_nxt;
  nvmp_pkg::nvmp_regreq_t req;
  logic [7:0] rd_data;
  logic loading;

  assign loading = (s_r.phase == nvmp_pkg::NVMP_LOAD);

  nvmp_axil_slave u_bus (
    .clk(clk),
    .rst_n(rst_n),
    .stall(loading),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .req(req),
    .wr_mapped(writable(req.wr_idx)),
    .rd_mapped(mapped(s_axi_araddr[5:2])),
    .rd_data(rd_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // read mux

  logic idx_ok;
  logic [15:0] sel_word;

  assign idx_ok = (s_r.command_word_index <= `NVMP_CCOB_IDX_MAX);
  // out-of-range index reads zero rather than aliasing a word
  assign sel_word = idx_ok ?
    s_r.ccob[s_r.command_word_index*16 +: 16] : 16'h0000;

  always_comb begin
    case (req.rd_idx)
      `NVMP_IDX_CMD_INDEX: rd_data = {5'h00, s_r.command_word_index};
      `NVMP_IDX_STATUS:
        rd_data = 8'(s_r.protection_violation_flag) << `NVMP_STAT_VIOL_BIT;
      `NVMP_IDX_FLASH_PROTECT_CTRL: rd_data = s_r.flash_protect_ctrl;
      `NVMP_IDX_EEPROM_PROTECT_CTRL: rd_data = s_r.eeprom_protect_ctrl;
      `NVMP_IDX_CCOB_HI: rd_data = sel_word[15:8];
      `NVMP_IDX_CCOB_LO: rd_data = sel_word[7:0];
      `NVMP_IDX_OPTION: rd_data = s_r.option_bits;
      default: rd_data = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // flash protection write filter

  nvmp_pkg::nvmp_flash_protect_ctrl_t fp_wr;
  nvmp_pkg::nvmp_flash_protect_ctrl_t fp_new;
  logic to_closed;

  assign fp_wr = req.wdata;
  // sense may only leave protect-ranges mode when both ranges go disabled,
  // which then protects the whole array
  assign to_closed = s_r.flash_protect_ctrl.range_sense_select &&
    !fp_wr.range_sense_select && fp_wr.upper_range_disable &&
    fp_wr.lower_range_disable;

  always_comb begin
    fp_new = s_r.flash_protect_ctrl;
    if (to_closed) begin
      fp_new.range_sense_select = 1'b0;
      fp_new.upper_range_disable = 1'b1;
      fp_new.lower_range_disable = 1'b1;
    end else if (s_r.flash_protect_ctrl.range_sense_select) begin
      // protected ranges: enabling a range only adds protection
      if (!fp_wr.upper_range_disable) begin
        fp_new.upper_range_disable = 1'b0;
      end
      if (!fp_wr.lower_range_disable) begin
        fp_new.lower_range_disable = 1'b0;
      end
    end else begin
      // unprotected ranges: disabling a range only adds protection
      if (fp_wr.upper_range_disable) begin
        fp_new.upper_range_disable = 1'b1;
      end
      if (fp_wr.lower_range_disable) begin
        fp_new.lower_range_disable = 1'b1;
      end
    end
    // sizes move only while their range is disabled, so no live change
    if (s_r.flash_protect_ctrl.upper_range_disable) begin
      fp_new.upper_range_size = fp_wr.upper_range_size;
    end
    if (s_r.flash_protect_ctrl.lower_range_disable) begin
      fp_new.lower_range_size = fp_wr.lower_range_size;
    end
    fp_new.fixed_one = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // eeprom protection write filter

  nvmp_pkg::nvmp_eeprom_protect_ctrl_t ee_wr;
  nvmp_pkg::nvmp_eeprom_protect_ctrl_t ee_new;

  assign ee_wr = req.wdata;

  always_comb begin
    ee_new = s_r.eeprom_protect_ctrl;
    if (!ee_wr.eeprom_guard_enable_n) begin
      ee_new.eeprom_guard_enable_n = 1'b0;
    end
    if (ee_wr.eeprom_guard_size > s_r.eeprom_protect_ctrl.eeprom_guard_size) begin
      ee_new.eeprom_guard_size = ee_wr.eeprom_guard_size;
    end
    ee_new.zeros = 4'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  // operation check

  logic op_take;
  logic op_bad;

  assign op_take = op.valid && !loading;

  always_comb begin
    op_bad = 1'b0;
    if (op.eeprom) begin
      if (op.kind == nvmp_pkg::NVMP_OP_BLOCK_ERASE) begin
        op_bad = !s_r.eeprom_protect_ctrl.eeprom_guard_enable_n;
      end else begin
        op_bad = ee_prot(s_r.eeprom_protect_ctrl, op.addr);
      end
    end else begin
      if (op.kind == nvmp_pkg::NVMP_OP_BLOCK_ERASE) begin
        // with FLASH_UNIT_LOG2 up to 10 the ranges never cover the whole block, so open sense always
        // leaves some sector protected
        op_bad = !s_r.flash_protect_ctrl.range_sense_select ||
          !s_r.flash_protect_ctrl.upper_range_disable ||
          !s_r.flash_protect_ctrl.lower_range_disable;
      end else begin
        op_bad = flash_prot(s_r.flash_protect_ctrl, op.addr);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    s_nxt = s_r;
    s_nxt.op_done = 1'b0;
    s_nxt.op_refused = 1'b0;
    case (s_r.phase)
      nvmp_pkg::NVMP_LOAD: begin
        if (cfg_rd_valid) begin
          case (s_r.cfg_sel)
            2'h0: begin
              s_nxt.flash_protect_ctrl = cfg_rd_data;
              s_nxt.flash_protect_ctrl.fixed_one = 1'b1;
            end
            2'h1: begin
              s_nxt.eeprom_protect_ctrl = cfg_rd_data;
              s_nxt.eeprom_protect_ctrl.zeros = 4'h0;
            end
            default: begin
              s_nxt.option_bits = cfg_rd_data;
            end
          endcase
          s_nxt.cfg_sel = s_r.cfg_sel + 2'h1;
          if (s_r.cfg_sel == `NVMP_CFG_LAST_SEL) begin
            s_nxt.phase = nvmp_pkg::NVMP_RUN;
          end
        end
      end
      nvmp_pkg::NVMP_RUN: begin
        if (req.wr) begin
          case (req.wr_idx)
            `NVMP_IDX_CMD_INDEX:
              s_nxt.command_word_index = req.wdata[2:0];
            `NVMP_IDX_STATUS: begin
              // write one clears
              if (req.wdata[`NVMP_STAT_VIOL_BIT]) begin
                s_nxt.protection_violation_flag = 1'b0;
              end
            end
            `NVMP_IDX_FLASH_PROTECT_CTRL: s_nxt.flash_protect_ctrl = fp_new;
            `NVMP_IDX_EEPROM_PROTECT_CTRL: s_nxt.eeprom_protect_ctrl = ee_new;
            `NVMP_IDX_CCOB_HI: begin
              if (idx_ok) begin
                s_nxt.ccob[s_r.command_word_index*16+8 +: 8] =
                  req.wdata;
              end
            end
            `NVMP_IDX_CCOB_LO: begin
              if (idx_ok) begin
                s_nxt.ccob[s_r.command_word_index*16 +: 8] =
                  req.wdata;
              end
            end
            default: begin
            end
          endcase
        end
        if (op_take) begin
          s_nxt.op_done = 1'b1;
          s_nxt.op_refused = op_bad;
          // a new violation beats a clear in the same cycle
          if (op_bad) begin
            s_nxt.protection_violation_flag = 1'b1;
          end
        end
      end
      default: begin
        s_nxt.phase = nvmp_pkg::NVMP_LOAD;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
      s_r.phase <= nvmp_pkg::NVMP_LOAD;
      s_r.flash_protect_ctrl <= `NVMP_FLASH_PROTECT_CTRL_RST;
      s_r.eeprom_protect_ctrl <= `NVMP_EEPROM_PROTECT_CTRL_RST;
      s_r.option_bits <= `NVMP_OPTION_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  assign cfg_rd_req = loading;
  always_comb begin
    case (s_r.cfg_sel)
      2'h0: cfg_rd_addr = `NVMP_CFG_FLASH_PROTECT_CTRL_ADDR;
      2'h1: cfg_rd_addr = `NVMP_CFG_EEPROM_PROTECT_CTRL_ADDR;
      default: cfg_rd_addr = `NVMP_CFG_OPTION_ADDR;
    endcase
  end
  assign op_ready = !loading;
  assign op_done = s_r.op_done;
  assign op_refused = s_r.op_refused;
  assign protection_violation_flag = s_r.protection_violation_flag;
  assign option_bits = s_r.option_bits;
  assign command_word = sel_word;

endmodule

// file: nvmp_top_chk.sv
// Purpose: port assertions for nvmp_top
// Assumes: one clock, async low reset
// Notes: read index kept from araddr bits 5:2
`timescale 1ns/1ps
module nvmp_top_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic cfg_rd_req,
  input wire logic [15:0] cfg_rd_addr,
  input wire logic cfg_rd_valid,
  input wire logic [7:0] cfg_rd_data,
  input wire nvmp_pkg::nvmp_op_t op,
  input wire logic op_ready,
  input wire logic op_done,
  input wire logic op_refused,
  input wire logic protection_violation_flag,
  input wire logic [7:0] option_bits
);
  logic [3:0] ridx_r;
  logic [3:0] ridx_nxt;
  logic cfg_take;
  assign cfg_take = cfg_rd_req && cfg_rd_valid;
  assign ridx_nxt = (s_axi_arvalid && s_axi_arready) ?
    s_axi_araddr[5:2] : ridx_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) ridx_r <= 4'h0;
    else ridx_r <= ridx_nxt;
  end
  ////////////////////////////////
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  cfg_first_a: assert property (
    cfg_take && cfg_rd_addr == 16'hff7c |=> cfg_rd_addr == 16'hff7d)
    else $error("config order after first byte");
  cfg_second_a: assert property (
    cfg_take && cfg_rd_addr == 16'hff7d |=> cfg_rd_addr == 16'hff7e)
    else $error("config order after second byte");
  opt_load_a: assert property (
    cfg_take && cfg_rd_addr == 16'hff7e
    |=> option_bits == $past(cfg_rd_data) && !cfg_rd_req && op_ready)
    else $error("option byte not loaded");
  opt_hold_a: assert property (
    op_ready && $past(op_ready) |-> $stable(option_bits))
    else $error("option byte changed");
  op_answer_a: assert property (
    op.valid && op_ready |=> op_done)
    else $error("op not answered");
  op_idle_a: assert property (
    !op_ready |=> !op_done)
    else $error("op answered while loading");
  viol_set_a: assert property (
    op_done && op_refused |-> protection_violation_flag)
    else $error("refusal without violation flag");
  fixed_one_a: assert property (
    s_axi_rvalid && ridx_r == 4'h8 |-> s_axi_rdata[6])
    else $error("flash bit 6 not one");
  ee_zeros_a: assert property (
    s_axi_rvalid && ridx_r == 4'h9 |-> s_axi_rdata[6:3] == 4'h0)
    else $error("eeprom bits 6:3 not zero");
  cover property (op_done && op_refused);
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  cover property (s_axi_rvalid && ridx_r == 4'h9);
endmodule
bind nvmp_top nvmp_top_chk chk_i (.clk, .rst_n, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_bresp, .s_axi_bvalid, .cfg_rd_req, .cfg_rd_addr, .cfg_rd_valid,
  .cfg_rd_data, .op, .op_ready, .op_done, .op_refused,
  .protection_violation_flag, .option_bits);

// file: tb.sv
// Purpose: self-checking bench for nvmp_top
// Assumes: bench answers the config byte port
// Notes: drivers queue results, negedge monitor compares
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, cfg_rd_req, op_ready, op_done, op_refused;
  logic protection_violation_flag;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic [15:0] cfg_rd_addr, command_word;
  logic [7:0] option_bits, opt, cfg_rd_data = '0;
  logic cfg_rd_valid = 1'b0;
  nvmp_pkg::nvmp_op_t op = '0;
  int seed = 32'h0b62e028;
  int bad_count = 0, n_checks = 0;
  logic [1:0] wq[$];
  logic [33:0] rq[$];
  logic oq[$];
  logic [15:0] cw[7];
  nvmp_top nvmp_top_i (.clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cfg_rd_req,
    .cfg_rd_addr, .cfg_rd_valid, .cfg_rd_data, .op, .op_ready, .op_done,
    .op_refused, .protection_violation_flag, .option_bits,
    .command_word);
  initial begin
    forever #12.5 clk = ~clk;
  end
  // valid every other cycle: a byte is taken, then the next address shows
  always @(posedge clk) begin
    cfg_rd_valid <= cfg_rd_req && !cfg_rd_valid;
    case (cfg_rd_addr)
      16'hff7c: cfg_rd_data <= 8'hbf;
      16'hff7d: cfg_rd_data <= 8'hfa;
      default: cfg_rd_data <= opt;
    endcase
  end
  ////////////////////////////////
  task automatic chk(input logic [33:0] g, input logic [33:0] e);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [3:0] i, input logic [7:0] d,
    input logic [1:0] r = 2'h0);
    wq.push_back(r);
    s_axi_awaddr <= {26'h0, i, 2'h0};
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    fork
      begin
        do @(negedge clk); while (!s_axi_awready);
        @(posedge clk) s_axi_awvalid <= 1'b0;
      end
      begin
        do @(negedge clk); while (!s_axi_wready);
        @(posedge clk) s_axi_wvalid <= 1'b0;
      end
    join
    do @(negedge clk); while (!s_axi_bvalid);
    @(posedge clk);
  endtask
  task automatic rd(input logic [3:0] i, input logic [7:0] e,
    input logic [1:0] r = 2'h0);
    rq.push_back({r, 24'h0, e});
    s_axi_araddr <= {26'h0, i, 2'h0};
    s_axi_arvalid <= 1'b1;
    do @(negedge clk); while (!s_axi_arready);
    @(posedge clk) s_axi_arvalid <= 1'b0;
    do @(negedge clk); while (!s_axi_rvalid);
    @(posedge clk);
  endtask
  task automatic opq(input logic [1:0] k, input logic e,
    input logic [15:0] a, input logic r);
    oq.push_back(r);
    op <= {1'b1, k, e, a};
    @(posedge clk) op <= {1'b0, k, e, a};
    @(posedge clk);
  endtask
  ////////////////////////////////
  always @(negedge clk) begin
    if (s_axi_bvalid)
      chk({32'h0, s_axi_bresp}, {32'h0, wq.pop_front()});
    if (s_axi_rvalid)
      chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (op_done)
      chk({33'h0, op_refused}, {33'h0, oq.pop_front()});
  end
  initial begin
    #200000;
    bad_count++;
    finish_test();
  end
  initial begin
    opt = 8'($random(seed));
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    rd(4'h8, 8'hff);
    rd(4'h9, 8'h82);
    rd(4'hc, opt);
    wr(4'hc, ~opt, 2'h2);
    rd(4'hc, opt);
    wr(4'hf, 8'h11, 2'h2);
    rd(4'hf, 8'h00, 2'h2);
    opq(2'h0, 1'b0, 16'hffff, 1'b0);
    opq(2'h2, 1'b0, 16'h8000, 1'b0);
    opq(2'h0, 1'b1, 16'h0000, 1'b0);
    opq(2'h2, 1'b1, 16'h0000, 1'b0);
    wr(4'h8, 8'hc0);
    rd(4'h8, 8'hc0);
    opq(2'h0, 1'b0, 16'hfc00, 1'b1);
    opq(2'h0, 1'b0, 16'hfbff, 1'b0);
    opq(2'h1, 1'b0, 16'h83ff, 1'b1);
    opq(2'h1, 1'b0, 16'h8400, 1'b0);
    opq(2'h2, 1'b0, 16'h8000, 1'b1);
    wr(4'h8, 8'hff);
    rd(4'h8, 8'hc0);
    wr(4'h8, 8'h24);
    rd(4'h8, 8'h64);
    opq(2'h0, 1'b0, 16'h9000, 1'b1);
    rd(4'h6, 8'h10);
    wr(4'h6, 8'h10);
    rd(4'h6, 8'h00);
    wr(4'h9, 8'h01);
    rd(4'h9, 8'h02);
    opq(2'h0, 1'b1, 16'h005f, 1'b1);
    opq(2'h1, 1'b1, 16'h0060, 1'b0);
    opq(2'h2, 1'b1, 16'h0100, 1'b1);
    wr(4'h9, 8'h83);
    rd(4'h9, 8'h03);
    for (int i = 0; i < 7; i++) begin
      cw[i] = 16'($random(seed));
      wr(4'h1, 8'(i));
      wr(4'ha, cw[i][15:8]);
      wr(4'hb, cw[i][7:0]);
    end
    cw[6] = '0;
    for (int i = 6; i >= 0; i--) begin
      wr(4'h1, 8'(i));
      @(negedge clk) chk(34'(command_word), 34'(cw[i]));
      @(posedge clk);
      rd(4'ha, cw[i][15:8]);
      rd(4'hb, cw[i][7:0]);
    end
    repeat (4) @(posedge clk);
    chk(34'(rq.size() + wq.size() + oq.size()), '0);
    finish_test();
  end
endmodule
